// ---- adc_afe_model.sv ----
// adc_afe_model: analog front end stand-in that hands over a code.
// assumes the code is taken only while a conversion is running.
`timescale 1ns/10ps

module adc_afe_model (
  // clock
  input wire logic                 mclk,
  // converter side
  input wire adc_pkg::adc_analog_t analog,
  input wire logic signed [11:0]   level,
  output logic signed [11:0]       sample_code
);
  logic signed [11:0] junk = 12'sh5a5;

  // outside a conversion the code means nothing, so keep it moving
  always @(posedge mclk) junk <= ~junk;
  assign sample_code = analog.busy ? level : junk;
endmodule

// ---- adc_cfg.svh ----
// adc_cfg.svh: register indices, field positions, reset values and
// conversion lengths for the converter control block.
// assumes it is included by its bare name wherever a figure is needed.
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

// register indices; byte address is four times the index
`define ADC_IDX_CTRL_B      3'h3
`define ADC_IDX_RES_LOW     3'h4
`define ADC_IDX_RES_HIGH    3'h5
`define ADC_IDX_CTRL_A      3'h6
`define ADC_IDX_INPUT_SEL   3'h7

// control/status a fields
`define ADC_A_POWER         7
`define ADC_A_GO            6
`define ADC_A_AUTO          5
`define ADC_A_DONE          4
`define ADC_A_ALLOW         3
`define ADC_A_DIV_HI        2
`define ADC_A_DIV_LO        0

// control/status b fields
`define ADC_B_BIPOLAR       7
`define ADC_B_CHAN_MSB      3
`define ADC_B_TRIG_HI       2
`define ADC_B_TRIG_LO       0

// input selector fields
`define ADC_S_REF_HI        7
`define ADC_S_REF_LO        6
`define ADC_S_LEFT          5
`define ADC_S_CHAN_HI       4
`define ADC_S_CHAN_LO       0

// reset values
`define ADC_RST_BYTE        8'h00
`define ADC_RST_RESULT      10'h000

// conversion lengths in converter clock cycles
`define ADC_LEN_FIRST       5'h19
`define ADC_LEN_NORMAL      5'h0d

// trigger source code that means free running
`define ADC_TRIG_FREE       3'h0

// result limits
`define ADC_UNI_MAX         12'sh3ff
`define ADC_BIP_MAX         12'sh1ff
`define ADC_BIP_MIN         -12'sh200

// channel codes that are single ended
`define ADC_CH_SE_LAST      6'h0a
`define ADC_CH_REF_BG       6'h1e
`define ADC_CH_GND          6'h1f
`define ADC_CH_TEMP         6'h3f

`endif

// ---- adc_clk_div.sv ----
// adc_clk_div: converter clock prescaler, one tick pulse per divided period.
// assumes the divider select is stable while run is high.
`timescale 1ns/10ps
`include "adc_cfg.svh"

module adc_clk_div #(
  parameter int CNT_W = 7
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // control
  input  wire logic       run,
  input  wire logic [2:0] div_sel,
  // tick
  output logic            tick
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] last;

  // codes 0 and 1 both divide by two
  always_comb begin
    if (div_sel < 3'h2) begin
      last = CNT_W'(1);
    end else begin
      last = CNT_W'((1 << div_sel) - 1);
    end
  end

  // held at zero while the converter is off to save power
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else if (!run) begin
      count <= '0;
    end else if (count >= last) begin
      count <= '0;
    end else begin
      count <= count + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tick <= 1'b0;
    end else begin
      tick <= run && (count >= last);
    end
  end

endmodule

// ---- adc_control_and_result_test.sv ----
// adc_control_and_result_test: self-checking bench for the converter.
// assumes adc_ctl_top, its bound monitor and the front-end model.
`timescale 1ns/10ps

module adc_control_and_result_test;
  logic                 mclk;
  logic                 reset;
  adc_pkg::adc_wb_req_t req;
  logic [31:0]          wb_dat_o;
  logic                 wb_ack_o;
  logic signed [11:0]   level;
  logic signed [11:0]   sample_code;
  adc_pkg::adc_analog_t analog;
  logic [7:0]           trig_in;
  logic                 gie;
  logic                 irq_taken;
  logic                 irq;
  int                   failures;
  int                   samples_checked;
  int                   bsy;
  logic [9:0]           last;
  logic [15:0]          s;
  logic [7:0]           r;

  adc_ctl_top dut (.mclk(mclk), .reset(reset), .wb_req(req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_code(sample_code),
    .analog(analog), .trig_in(trig_in), .global_irq_enable(gie),
    .irq_taken(irq_taken), .irq(irq));
  adc_afe_model afe (.mclk(mclk), .analog(analog), .level(level),
    .sample_code(sample_code));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) if (analog.busy === 1'b1) bsy <= bsy + 1;

  task automatic report_and_stop;
    $display("checks %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, m,
        got, exp);
    end
  endtask

  // one classic cycle; read data lands in r
  task automatic bus(input logic [4:0] a, input logic w,
                     input logic [7:0] d);
    @(posedge mclk);
    req.cyc <= 1'b1;
    req.stb <= 1'b1;
    req.we <= w;
    req.adr <= {27'h0, a};
    req.sel <= 4'h1;
    req.dat <= {24'h0, d};
    // only the watchdog ends a wait for an ack that never comes
    do begin
      @(posedge mclk);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o[7:0];
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [9:0] exp_res(input logic signed [11:0] c,
                                         input logic bip,
                                         input logic [5:0] ch);
    logic signed [11:0] v;
    logic               dif;
    dif = !(ch <= 6'h0a || ch == 6'h1e || ch == 6'h1f || ch == 6'h3f);
    v = (dif && bip) ? c >>> 1 : c;
    if (dif && bip) begin
      if (v > 12'sh1ff) v = 12'sh1ff;
      if (v < -12'sh200) v = -12'sh200;
    end else begin
      if (v > 12'sh3ff) v = 12'sh3ff;
      if (v < 12'sh000) v = 12'sh000;
    end
    return v[9:0];
  endfunction

  // f = {bipolar, left align, irq allow, read low first}
  task automatic conv(input logic [11:0] c, input logic [5:0] ch,
                      input logic [3:0] f, input logic [2:0] dv,
                      input int n);
    int         d;
    int         k;
    logic [9:0] e;
    d = (dv < 3'h2) ? 2 : (1 << dv);
    e = f[0] ? last : exp_res(c, f[3], ch);
    last = e;
    level <= c;
    bus(5'h1c, 1'b1, {2'b10, f[2], ch[4:0]});
    bus(5'h0c, 1'b1, {f[3], 3'h0, ch[5], 3'h0});
    if (f[0]) bus(5'h10, 1'b0, 8'h00);
    bsy = 0;
    bus(5'h18, 1'b1, {4'hc, f[1], dv});
    k = 0;
    do begin
      bus(5'h18, 1'b0, 8'h00);
      if (k == 0) chk(r[6], 1'b1, "go busy");
      k++;
    end while (r[6] && k < 1200);
    chk(r[4], 1'b1, "done");
    chk(bsy >= (n - 1) * d && bsy <= n * d + 2, 1'b1, "length");
    chk(irq, f[1] & gie, "irq");
    bus(5'h10, 1'b0, 8'h00);
    chk(r, f[2] ? {e[1:0], 6'h00} : e[7:0], "low");
    bus(5'h14, 1'b0, 8'h00);
    chk(r, f[2] ? e[9:2] : {6'h00, e[9:8]}, "high");
    if (f[1]) begin
      @(posedge mclk);
      irq_taken <= 1'b1;
      @(posedge mclk);
      irq_taken <= 1'b0;
    end else
      bus(5'h18, 1'b1, {5'h12, dv});
    bus(5'h18, 1'b0, 8'h00);
    chk(r[4], 1'b0, "done clear");
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    report_and_stop;
  end

  initial begin
    reset = 1'b1;
    req = '0;
    level = 12'sh000;
    trig_in = 8'h00;
    gie = 1'b0;
    irq_taken = 1'b0;
    failures = 0;
    samples_checked = 0;
    bsy = 0;
    last = 10'h000;
    s = 16'h9705;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    bus(5'h10, 1'b1, 8'hff);
    for (int i = 0; i < 8; i++) begin
      bus(5'(i * 4), 1'b0, 8'h00);
      chk(r, 8'h00, "reset");
    end
    conv(12'sh2bc, 6'h00, 4'h0, 3'h0, 25);
    conv(-12'sh005, 6'h05, 4'h4, 3'h1, 13);
    conv(12'sh7d0, 6'h0c, 4'h0, 3'h2, 13);
    conv(-12'sh12c, 6'h21, 4'h0, 3'h0, 13);
    gie <= 1'b1;
    conv(-12'sh12c, 6'h21, 4'ha, 3'h0, 13);
    conv(12'sh5dc, 6'h0c, 4'he, 3'h0, 13);
    conv(-12'sh7d0, 6'h0c, 4'h8, 3'h0, 13);
    conv(12'sh12c, 6'h3f, 4'h8, 3'h3, 13);
    conv(12'sh0aa, 6'h00, 4'h5, 3'h0, 13);
    for (int i = 0; i < 8; i++)
      conv(12'sh100, 6'h01, 4'h0, 3'(i), 13);
    for (int i = 0; i < 6; i++) begin
      s = lfsr(s);
      gie <= s[15];
      conv(s[11:0], s[13] ? 6'h0c : 6'h03, {s[12], s[14], s[15], 1'b0},
        s[2:0], 13);
    end
    bus(5'h0c, 1'b1, 8'h01);
    bus(5'h18, 1'b1, 8'hb0);
    @(posedge mclk);
    trig_in <= 8'h02;
    @(posedge mclk);
    trig_in <= 8'h00;
    for (int k = 0; k < 60 && r[4] !== 1'b1; k++)
      bus(5'h18, 1'b0, 8'h00);
    chk(r[4], 1'b1, "trigger");
    bus(5'h0c, 1'b1, 8'h00);
    // second pass writes no go bit, so done must come from a restart
    for (int j = 0; j < 2; j++) begin
      bus(5'h18, 1'b1, (j == 0) ? 8'hf0 : 8'hb0);
      r = 8'h00;
      for (int k = 0; k < 60 && r[4] !== 1'b1; k++)
        bus(5'h18, 1'b0, 8'h00);
      chk(r[4], 1'b1, "free run");
    end
    bus(5'h18, 1'b1, 8'h10);
    bus(5'h18, 1'b1, 8'hd7);
    repeat (20) @(posedge mclk);
    bus(5'h18, 1'b1, 8'h17);
    bus(5'h18, 1'b0, 8'h00);
    chk(r, 8'h07, "abort");
    chk(analog.busy, 1'b0, "abort busy");
    conv(12'sh155, 6'h02, 4'h0, 3'h0, 25);
    bus(5'h1c, 1'b1, 8'h62);
    bus(5'h10, 1'b0, 8'h00);
    chk(r, {last[1:0], 6'h00}, "realign low");
    bus(5'h14, 1'b0, 8'h00);
    chk(r, last[9:2], "realign high");
    conv(12'sh0ff, 6'h02, 4'h0, 3'h0, 25);
    report_and_stop;
  end
endmodule

// ---- adc_ctl_monitor.sv ----
// adc_ctl_monitor: temporal checks on the converter control ports.
// assumes it is bound into adc_ctl_top and sees only its ports.
`timescale 1ns/10ps

module adc_ctl_monitor #(
  parameter int CODE_W = 12
) (
  // clock and reset
  input wire logic                     mclk,
  input wire logic                     reset,
  // wishbone
  input wire adc_pkg::adc_wb_req_t     wb_req,
  input wire logic [31:0]              wb_dat_o,
  input wire logic                     wb_ack_o,
  // front end
  input wire logic signed [CODE_W-1:0] sample_code,
  input wire adc_pkg::adc_analog_t     analog,
  // triggers and interrupt
  input wire logic [7:0]               trig_in,
  input wire logic                     global_irq_enable,
  input wire logic                     irq_taken,
  input wire logic                     irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence wr_a_s;
    wb_req.cyc && wb_req.stb && !wb_ack_o && wb_req.we &&
      wb_req.sel[0] && wb_req.adr[4:2] == 3'h6;
  endsequence
  sequence go_s;
    wr_a_s ##0 (wb_req.dat[7:6] == 2'b11 && !analog.busy);
  endsequence
  sequence off_s;
    wr_a_s ##0 !wb_req.dat[7];
  endsequence
  // the shortest conversion is 13 ticks of at least 2 clocks
  sequence long_s;
    analog.busy [*8];
  endsequence

  go_start_a: assert property (go_s |-> ##[1:2] analog.busy)
    else $error("go write did not start a conversion");
  off_abort_a: assert property (off_s |->
    ##[1:2] (!analog.power && !analog.busy))
    else $error("power off left the converter running");
  idle_off_a: assert property (!analog.power |-> !analog.busy)
    else $error("conversion running while unpowered");
  conv_min_a: assert property ($rose(analog.busy) |-> long_s)
    else $error("conversion ended too early");
  ref_hold_a: assert property ($rose(analog.busy) |=>
    $stable(analog.ref_sel) [*7])
    else $error("reference changed inside a conversion");
  irq_mask_a: assert property (!global_irq_enable |=> !irq)
    else $error("interrupt raised while globally masked");
  irq_cause_a: assert property (
    $rose(irq) |-> $past(global_irq_enable))
    else $error("interrupt rose without global enable");
  taken_clear_a: assert property (
    irq_taken && !analog.busy |-> ##2 !irq)
    else $error("interrupt stayed after vector taken");
endmodule

bind adc_ctl_top adc_ctl_monitor #(.CODE_W(CODE_W)) mon (
  .mclk(mclk), .reset(reset), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .sample_code(sample_code), .analog(analog),
  .trig_in(trig_in), .global_irq_enable(global_irq_enable),
  .irq_taken(irq_taken), .irq(irq));

// ---- adc_ctl_top.sv ----
// adc_ctl_top: converter control, status and result formatting behind a
// classic wishbone slave.
// assumes the analog front end presents, at the end of each conversion,
// the quantized gained input times 1024 over reference as a signed code.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "adc_cfg.svh"

module adc_ctl_top #(
  parameter int CODE_W = 12
) (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     reset,
  // wishbone slave
  input  wire adc_pkg::adc_wb_req_t     wb_req,
  output logic [31:0]                   wb_dat_o,
  output logic                          wb_ack_o,
  // analog front end
  input  wire logic signed [CODE_W-1:0] sample_code,
  output adc_pkg::adc_analog_t          analog,
  // triggers and core interrupt handshake
  input  wire logic [7:0]               trig_in,
  input  wire logic                     global_irq_enable,
  input  wire logic                     irq_taken,
  output logic                          irq
);

  // software visible state, plus the hidden result read lock
  logic       converter_power_on;
  logic       auto_trigger_on;
  logic       conversion_done_flag;
  logic       done_irq_allow;
  logic [2:0] clock_divider_select;
  logic       bipolar_select;
  logic [2:0] trigger_source_select;
  logic [1:0] reference_select;
  logic       left_align_result;
  logic [5:0] input_channel_select;
  logic [9:0] result;
  logic       result_lock;

  // conversion engine
  adc_pkg::adc_state_t state;
  logic [4:0]          tick_count;
  logic [4:0]          conv_len;
  logic                need_init;
  logic [1:0]          ref_active;
  logic                trig_q;
  logic                tick;

  // bus decode
  wire logic [2:0] idx    = wb_req.adr[4:2];
  wire logic       access = wb_req.cyc && wb_req.stb && !wb_ack_o;
  wire logic       wr     = access && wb_req.we && wb_req.sel[0];
  wire logic       rd     = access && !wb_req.we;
  wire logic [7:0] wdat   = wb_req.dat[7:0];
  wire logic       wr_a   = wr && (idx == `ADC_IDX_CTRL_A);
  wire logic       wr_b   = wr && (idx == `ADC_IDX_CTRL_B);
  wire logic       wr_s   = wr && (idx == `ADC_IDX_INPUT_SEL);

  // trigger selection and edge
  wire logic trig_now  = trig_in[trigger_source_select];
  wire logic trig_rise = trig_now && !trig_q;
  wire logic free_run  = (trigger_source_select == `ADC_TRIG_FREE);

  // conversion events
  wire logic finish     = (state == adc_pkg::adc_conv) && tick &&
                          (tick_count == conv_len - 5'h01);
  wire logic abort      = wr_a && !wdat[`ADC_A_POWER];
  wire logic go_write   = wr_a && wdat[`ADC_A_GO] &&
                          wdat[`ADC_A_POWER];
  wire logic auto_start = converter_power_on && auto_trigger_on &&
                          ((!free_run && trig_rise) ||
                           (free_run && finish));
  wire logic start      = !abort && (go_write || auto_start) &&
                          (state == adc_pkg::adc_idle || finish);
  wire logic ref_change = wr_s && (wdat[`ADC_S_REF_HI:`ADC_S_REF_LO] !=
                                   reference_select);

  // result formatting
  logic               differential;
  logic signed [CODE_W-1:0] half_code;
  logic [9:0]         next_result;

  // single ended codes: 0..10, fixed sources, temperature sensor
  assign differential = !(input_channel_select <= `ADC_CH_SE_LAST ||
                          input_channel_select == `ADC_CH_REF_BG ||
                          input_channel_select == `ADC_CH_GND ||
                          input_channel_select == `ADC_CH_TEMP);

  always_comb begin
    half_code = sample_code >>> 1;
    if (differential && bipolar_select) begin
      if (half_code > `ADC_BIP_MAX) begin
        next_result = 10'(`ADC_BIP_MAX);
      end else if (half_code < `ADC_BIP_MIN) begin
        next_result = 10'(`ADC_BIP_MIN);
      end else begin
        next_result = half_code[9:0];
      end
    end else if (sample_code < 0) begin
      next_result = `ADC_RST_RESULT;
    end else if (sample_code > `ADC_UNI_MAX) begin
      next_result = 10'(`ADC_UNI_MAX);
    end else begin
      next_result = sample_code[9:0];
    end
  end

  adc_clk_div #(
    .CNT_W (7)
  ) u_div (
    .mclk    (mclk),
    .reset   (reset),
    .run     (converter_power_on),
    .div_sel (clock_divider_select),
    .tick    (tick)
  );

  // control/status a
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      converter_power_on   <= 1'b0;
      auto_trigger_on      <= 1'b0;
      done_irq_allow       <= 1'b0;
      clock_divider_select <= 3'h0;
    end else if (wr_a) begin
      converter_power_on   <= wdat[`ADC_A_POWER];
      auto_trigger_on      <= wdat[`ADC_A_AUTO];
      done_irq_allow       <= wdat[`ADC_A_ALLOW];
      clock_divider_select <= wdat[`ADC_A_DIV_HI:`ADC_A_DIV_LO];
    end
  end

  // done flag: a completion in the clearing cycle wins
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      conversion_done_flag <= 1'b0;
    end else if (finish) begin
      conversion_done_flag <= 1'b1;
    end else if (irq_taken || (wr_a && wdat[`ADC_A_DONE])) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // control/status b and input selector
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bipolar_select        <= 1'b0;
      trigger_source_select <= 3'h0;
      reference_select      <= 2'h0;
      left_align_result     <= 1'b0;
      input_channel_select  <= 6'h00;
    end else begin
      if (wr_b) begin
        bipolar_select          <= wdat[`ADC_B_BIPOLAR];
        trigger_source_select   <= wdat[`ADC_B_TRIG_HI:`ADC_B_TRIG_LO];
        input_channel_select[5] <= wdat[`ADC_B_CHAN_MSB];
      end
      if (wr_s) begin
        reference_select          <= wdat[`ADC_S_REF_HI:`ADC_S_REF_LO];
        left_align_result         <= wdat[`ADC_S_LEFT];
        input_channel_select[4:0] <= wdat[`ADC_S_CHAN_HI:`ADC_S_CHAN_LO];
      end
    end
  end

  // conversion sequencer
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state      <= adc_pkg::adc_idle;
      tick_count <= 5'h00;
      conv_len   <= `ADC_LEN_NORMAL;
    end else if (abort) begin
      state      <= adc_pkg::adc_idle;
      tick_count <= 5'h00;
    end else if (start) begin
      state      <= adc_pkg::adc_conv;
      tick_count <= 5'h00;
      conv_len   <= (need_init || ref_change) ?
                    `ADC_LEN_FIRST : `ADC_LEN_NORMAL;
    end else begin
      case (state)
        adc_pkg::adc_conv: begin
          if (finish) begin
            state <= adc_pkg::adc_idle;
          end else if (tick) begin
            tick_count <= tick_count + 5'h01;
          end
        end
        default: begin
          state <= adc_pkg::adc_idle;
        end
      endcase
    end
  end

  // long initialising conversion owed after enable or reference change
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      need_init <= 1'b1;
    end else if (abort) begin
      need_init <= 1'b1;
    end else if (start) begin
      need_init <= 1'b0;
    end else if (!converter_power_on || ref_change) begin
      need_init <= 1'b1;
    end
  end

  // reference seen by the front end only moves between conversions
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ref_active <= 2'h0;
    end else if (state == adc_pkg::adc_idle || finish) begin
      ref_active <= reference_select;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig_now;
    end
  end

  // result store, held while software is between low and high reads
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      result <= `ADC_RST_RESULT;
    end else if (finish && !result_lock) begin
      result <= next_result;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      result_lock <= 1'b0;
    end else if (rd && idx == `ADC_IDX_RES_HIGH) begin
      result_lock <= 1'b0;
    end else if (rd && idx == `ADC_IDX_RES_LOW) begin
      result_lock <= 1'b1;
    end
  end

  // read mux; alignment applies at read time so it follows the bit at once
  logic [7:0] rd_byte;

  always_comb begin
    case (idx)
      `ADC_IDX_RES_LOW: begin
        rd_byte = left_align_result ? {result[1:0], 6'h00}
                                    : result[7:0];
      end
      `ADC_IDX_RES_HIGH: begin
        rd_byte = left_align_result ? result[9:2]
                                    : {6'h00, result[9:8]};
      end
      `ADC_IDX_CTRL_A: begin
        rd_byte = {converter_power_on,
                   state == adc_pkg::adc_conv,
                   auto_trigger_on, conversion_done_flag, done_irq_allow,
                   clock_divider_select};
      end
      `ADC_IDX_CTRL_B: begin
        rd_byte = {bipolar_select, 3'h0, input_channel_select[5],
                   trigger_source_select};
      end
      `ADC_IDX_INPUT_SEL: begin
        rd_byte = {reference_select, left_align_result,
                   input_channel_select[4:0]};
      end
      default: begin
        rd_byte = `ADC_RST_BYTE;
      end
    endcase
  end

  // one wait state: ack one edge after the request, dropped the next
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      if (rd) begin
        wb_dat_o <= {24'h00_0000, rd_byte};
      end
    end
  end

  // interrupt request
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= conversion_done_flag && done_irq_allow &&
             global_irq_enable;
    end
  end

  // analog front end controls
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      analog <= '0;
    end else begin
      analog.power   <= converter_power_on;
      analog.busy    <= (state == adc_pkg::adc_conv) && !finish;
      analog.ref_sel <= ref_active;
      analog.channel <= input_channel_select;
      analog.bipolar <= bipolar_select;
    end
  end

endmodule

// ---- adc_pkg.sv ----
// adc_pkg: types shared by the converter control block.
// assumes a 32-bit classic wishbone bus and an external analog front end.
package adc_pkg;

  typedef enum logic {
    adc_idle,
    adc_conv
  } adc_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [31:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } adc_wb_req_t;

  typedef struct packed {
    logic       power;
    logic       busy;
    logic [1:0] ref_sel;
    logic [5:0] channel;
    logic       bipolar;
  } adc_analog_t;

endpackage
